// ===== ssms_core.sv
// Synchronous half-duplex serial transceiver: master receive/transmit
// and slave receive/transmit on a shared clock pin and data pin.
// Assumes a classic Wishbone master and an external peer on the pins.
//
// Chosen here: the Wishbone slave port and the register offsets.
module ssms_core (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [4:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic ck_i,
	output logic ck_o,
	output logic ck_oe_n_o,
	input wire logic dt_i,
	output logic dt_o,
	output logic dt_oe_n_o,
	output logic rx_irq_o,
	output logic tx_irq_o,
	output logic wake_o,
	output logic vector_o
);
	// The receive status byte joins software-written control bits with
	// flags that only the receiver owns, so each has a single driver
	logic [7:0] tx_ctl;
	logic [7:3] rx_ctl;
	logic [7:0] rx_stat;
	logic oe_flag;
	logic d9_flag;
	logic fe_flag;
	logic q_push;
	logic q_pop;
	logic q_full;
	logic q_empty;
	logic [15:0] div_eff;
	logic [7:0] baud;
	logic [15:0] divider;
	logic [4:0] irq_ctl;
	logic wr;
	logic rd;
	logic spe;
	logic sync_mode;
	logic master;
	logic slave;
	logic port_rst;
	logic [1:0] ck_sync;
	logic [1:0] dt_sync;
	logic ck_prev;
	logic lead_edge;
	logic trail_edge;
	logic [15:0] brg_cnt;
	logic brg_tick;
	logic ck_int;
	logic rx_mode;
	logic [8:0] rx_shift;
	logic [3:0] rx_cnt;
	logic [3:0] nbits_rx;
	logic [3:0] nbits_tx;
	logic [8:0] q_data [0:1];
	logic [1:0] q_cnt;
	logic q_rd_ptr;
	logic q_wr_ptr;
	logic rx_done;
	logic overrun;
	logic [7:0] tx_hold;
	logic tx_hold_d9;
	logic tx_hold_full;
	logic [8:0] tx_shift;
	logic [3:0] tx_cnt;
	logic tx_busy;
	logic tx_flag;
	logic rx_flag;
	logic master_run;

	assign wr = cyc_i && stb_i && we_i && sel_i[0] && !ack_o;
	assign rd = cyc_i && stb_i && !we_i && !ack_o;
	assign rx_stat = {rx_ctl, fe_flag, oe_flag, d9_flag};
	assign spe = rx_stat[ssms_pkg::RX_SPE];
	assign sync_mode = tx_ctl[ssms_pkg::TX_SYNC];
	assign master = sync_mode && spe && tx_ctl[ssms_pkg::TX_MCS];
	assign slave = sync_mode && spe && !tx_ctl[ssms_pkg::TX_MCS];
	assign port_rst = rst_i || !spe;
	// slave takes receive mode when either enable is set; it shifts in only with RX_CRE set
	assign rx_mode = slave ? (rx_stat[ssms_pkg::RX_SRE] ||
		rx_stat[ssms_pkg::RX_CRE]) : master_run;
	assign master_run = master && !overrun &&
		(rx_stat[ssms_pkg::RX_SRE] || rx_stat[ssms_pkg::RX_CRE]);
	assign nbits_rx = rx_stat[ssms_pkg::RX_N9] ? 4'h9 : 4'h8;
	assign nbits_tx = tx_ctl[ssms_pkg::TX_N9] ? 4'h9 : 4'h8;

	// Queue bookkeeping shared by the queue and the overrun flag
	assign q_full = q_cnt == 2'h2;
	assign q_empty = q_cnt == 2'h0;
	assign q_push = rx_done && !q_full;
	assign q_pop = rd && adr_i == ssms_pkg::ADDR_RX_DATA && !q_empty;

	// without the wide-divider select only the low byte counts
	assign div_eff = baud[ssms_pkg::BC_WIDE] ? divider :
		{8'h00, divider[7:0]};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
		end
	end

	// Two-flop synchronisers; only the second stage feeds logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ck_sync <= 2'h0;
			dt_sync <= 2'h0;
			ck_prev <= 1'b0;
		end else begin
			ck_sync <= {ck_sync[0], ck_i};
			dt_sync <= {dt_sync[0], dt_i};
			ck_prev <= ck_sync[1];
		end
	end

	// Baud generator: internal clock toggles each divider+1 cycles
	always_ff @(posedge clk_i) begin
		if (port_rst || !(master_run || tx_busy) || !master) begin
			brg_cnt <= 16'h0000;
			brg_tick <= 1'b0;
			ck_int <= 1'b0;
		end else if (brg_cnt >= div_eff) begin
			brg_cnt <= 16'h0000;
			brg_tick <= 1'b1;
			ck_int <= !ck_int;
		end else begin
			brg_cnt <= brg_cnt + 16'h0001;
			brg_tick <= 1'b0;
		end
	end

	// leading edge is rising clock, trailing is falling
	assign lead_edge = master ? (brg_tick && ck_int) :
		(slave && ck_sync[1] && !ck_prev);
	assign trail_edge = master ? (brg_tick && !ck_int) :
		(slave && !ck_sync[1] && ck_prev);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_ctl <= ssms_pkg::RST_TX_CTL;
			baud <= ssms_pkg::RST_BAUD;
			divider <= {ssms_pkg::RST_DIV, ssms_pkg::RST_DIV};
			irq_ctl <= ssms_pkg::RST_IRQ;
		end else if (wr) begin
			case (adr_i)
				ssms_pkg::ADDR_TX_CTL: begin
					// Idle bit is status only; software cannot fake it
					tx_ctl <= {dat_i[7:2], tx_ctl[1], dat_i[0]};
				end
				ssms_pkg::ADDR_BAUD_CTL: baud <= dat_i[7:0];
				ssms_pkg::ADDR_DIV_LOW: divider[7:0] <= dat_i[7:0];
				ssms_pkg::ADDR_DIV_HIGH: divider[15:8] <= dat_i[7:0];
				ssms_pkg::ADDR_IRQ_CTL: irq_ctl <= dat_i[4:0];
				default: begin
				end
			endcase
		end else begin
			tx_ctl[ssms_pkg::TX_IDLE] <= !tx_busy;
		end
	end

	// Receive status/control; single-receive self-clears after a character in master mode only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_ctl <= ssms_pkg::RST_RX_CTL[7:3];
		end else if (wr && adr_i == ssms_pkg::ADDR_RX_CTL) begin
			rx_ctl <= dat_i[7:3];
		end else if (rx_done && master) begin
			rx_ctl[ssms_pkg::RX_SRE] <= 1'b0;
		end
	end
	assign overrun = oe_flag;
	// Synchronous frames carry no stop bit, so no framing error can occur
	assign fe_flag = 1'b0;

	// overrun set on third character; cleared by dropping both cont and single enables
	always_ff @(posedge clk_i) begin
		if (port_rst || (!rx_stat[ssms_pkg::RX_CRE] &&
			!(master && rx_stat[ssms_pkg::RX_SRE]))) begin
			rx_shift <= 9'h000;
			rx_cnt <= 4'h0;
			rx_done <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (rx_mode && !overrun && trail_edge) begin
				rx_shift <= {dt_sync[1], rx_shift[8:1]};
				if (rx_cnt + 4'h1 == nbits_rx) begin
					rx_cnt <= 4'h0;
					rx_done <= 1'b1;
				end else begin
					rx_cnt <= rx_cnt + 4'h1;
				end
			end
		end
	end

	// Two-entry receive queue; a full queue never takes a third character,
	// so stored characters survive an overrun
	always_ff @(posedge clk_i) begin
		if (port_rst) begin
			q_cnt <= 2'h0;
			q_rd_ptr <= 1'b0;
			q_wr_ptr <= 1'b0;
		end else begin
			if (q_push) begin
				q_data[q_wr_ptr] <= rx_stat[ssms_pkg::RX_N9] ?
					rx_shift : {1'b0, rx_shift[8:1]};
				q_wr_ptr <= !q_wr_ptr;
			end
			if (q_pop) begin
				q_rd_ptr <= !q_rd_ptr;
			end
			q_cnt <= q_cnt + 2'(q_push) - 2'(q_pop);
		end
	end

	// Overrun flag; a third character wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (port_rst) begin
			oe_flag <= 1'b0;
		end else if (rx_done && q_full) begin
			oe_flag <= 1'b1;
		end else if (!rx_stat[ssms_pkg::RX_CRE] &&
			!rx_stat[ssms_pkg::RX_SRE]) begin
			oe_flag <= 1'b0;
		end
	end

	// Ninth bit follows the head of the queue, one cycle behind a pop
	always_ff @(posedge clk_i) begin
		if (port_rst) begin
			d9_flag <= 1'b0;
		end else begin
			d9_flag <= !q_empty && q_data[q_rd_ptr][8];
		end
	end
	assign rx_flag = !q_empty;

	// Transmit: hold register then shifter, shared by master and slave
	always_ff @(posedge clk_i) begin
		if (port_rst || !tx_ctl[ssms_pkg::TX_EN]) begin
			tx_hold <= 8'h00;
			tx_hold_d9 <= 1'b0;
			tx_hold_full <= 1'b0;
			tx_shift <= 9'h000;
			tx_cnt <= 4'h0;
			tx_busy <= 1'b0;
		end else begin
			if (wr && adr_i == ssms_pkg::ADDR_TX_DATA) begin
				tx_hold <= dat_i[7:0];
				tx_hold_d9 <= tx_ctl[ssms_pkg::TX_D9];
				tx_hold_full <= 1'b1;
			end else if (tx_hold_full && !tx_busy) begin
				// held word moves on in a later cycle than the flag is set, once the shifter is idle
				tx_shift <= {tx_hold_d9, tx_hold};
				tx_hold_full <= 1'b0;
				tx_busy <= 1'b1;
				tx_cnt <= 4'h0;
			end
			if (tx_busy && !rx_mode && trail_edge) begin
				tx_shift <= {1'b0, tx_shift[8:1]};
				if (tx_cnt + 4'h1 == nbits_tx) begin
					tx_busy <= 1'b0;
				end
				tx_cnt <= tx_cnt + 4'h1;
			end
		end
	end
	assign tx_flag = !tx_hold_full;

	// Data pin: driven on the leading edge for the next bit
	always_ff @(posedge clk_i) begin
		if (port_rst) begin
			dt_o <= 1'b0;
		end else if (lead_edge || !tx_busy) begin
			dt_o <= tx_shift[0];
		end
	end
	assign dt_oe_n_o = !(tx_busy && !rx_mode &&
		tx_ctl[ssms_pkg::TX_EN] && spe);
	always_ff @(posedge clk_i) begin
		if (port_rst) begin
			ck_o <= 1'b0;
		end else begin
			ck_o <= ck_int;
		end
	end
	assign ck_oe_n_o = !master;

	assign rx_irq_o = rx_flag && irq_ctl[ssms_pkg::IC_RIE];
	assign tx_irq_o = tx_flag && irq_ctl[ssms_pkg::IC_TIE] &&
		tx_ctl[ssms_pkg::TX_EN];
	assign wake_o = irq_ctl[ssms_pkg::IC_SLEEP] &&
		irq_ctl[ssms_pkg::IC_PIE] && (rx_irq_o || tx_irq_o);
	assign vector_o = irq_ctl[ssms_pkg::IC_GIE] &&
		irq_ctl[ssms_pkg::IC_PIE] && (rx_irq_o || tx_irq_o);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else begin
			case (adr_i)
				ssms_pkg::ADDR_TX_CTL: dat_o <= {24'h000000, tx_ctl};
				ssms_pkg::ADDR_RX_CTL: dat_o <= {24'h000000, rx_stat};
				ssms_pkg::ADDR_BAUD_CTL: dat_o <= {24'h000000, baud};
				ssms_pkg::ADDR_DIV_LOW: dat_o <= {24'h000000, divider[7:0]};
				ssms_pkg::ADDR_DIV_HIGH: dat_o <= {24'h000000, divider[15:8]};
				ssms_pkg::ADDR_RX_DATA: dat_o <= {24'h000000,
					q_data[q_rd_ptr][7:0]};
				ssms_pkg::ADDR_IRQ_CTL: dat_o <= {25'h0, tx_flag,
					rx_flag, irq_ctl};
				default: dat_o <= 32'h0000_0000;
			endcase
		end
	end
endmodule : ssms_core

// ===== ssms_core_assertions.sv
// Checker: bus handshake and status outputs of the transceiver.
// Assumes it is bound to ssms_core and sees only its ports.
module ssms_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [4:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic ck_oe_n_o,
	input wire logic dt_oe_n_o,
	input wire logic rx_irq_o,
	input wire logic tx_irq_o,
	input wire logic wake_o,
	input wire logic vector_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_once; ack_o |=> !ack_o; endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack too long");
	property p_ack_req; ack_o |-> cyc_i && stb_i; endproperty
	a_ack_req: assert property (p_ack_req) else $error("stray ack");
	property p_unmapped;
		ack_o && !we_i && adr_i[1:0] != 2'h0 |-> dat_o == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped data");
	property p_rst; $fell(rst_i) |-> ck_oe_n_o && dt_oe_n_o && !ack_o;
	endproperty
	a_rst: assert property (p_rst) else $error("pins after reset");
	property p_wake; wake_o |-> rx_irq_o || tx_irq_o; endproperty
	a_wake: assert property (p_wake) else $error("wake no cause");
	property p_vec; vector_o |-> rx_irq_o || tx_irq_o; endproperty
	a_vec: assert property (p_vec) else $error("vector no cause");
	// The flag only drops through a register access
	property p_rx_hold; $fell(rx_irq_o) |-> ack_o || $past(ack_o);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx irq lost");
endmodule : ssms_chk

bind ssms_core ssms_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.dat_o(dat_o), .ack_o(ack_o), .ck_oe_n_o(ck_oe_n_o),
	.dt_oe_n_o(dt_oe_n_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o),
	.wake_o(wake_o), .vector_o(vector_o));

// ===== ssms_peer.sv
// Remote synchronous master: makes the link clock and trades bits.
// Assumes the bench resolves the data line with a pull-up.
module ssms_peer (
	output logic ck_o,
	output logic dt_o,
	output logic dt_oe_n_o,
	input wire logic dt_i
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		ck_o = 1'b0;
		dt_o = 1'b1;
		dt_oe_n_o = 1'b1;
	end
	// Clock stands low between frames; LSB first, 320 ns per bit
	task automatic xfer(input logic [8:0] tx, input int n,
		input logic drv, output logic [8:0] rx);
		rx = 9'h000;
		#7;
		dt_oe_n_o = !drv;
		for (int i = 0; i < n; i++) begin
			dt_o = tx[i];
			ck_o = 1'b1;
			#160;
			ck_o = 1'b0;
			rx[i] = dt_i;
			#160;
		end
		dt_oe_n_o = 1'b1;
	endtask : xfer
endmodule : ssms_peer

// ===== ssms_pkg.sv
// Package for the synchronous serial master/slave transceiver block.
// Assumes a classic Wishbone slave with 32-bit data, byte addresses.
package ssms_pkg;
	// Register byte offsets
	localparam logic [4:0] ADDR_TX_CTL = 5'h00;
	localparam logic [4:0] ADDR_RX_CTL = 5'h04;
	localparam logic [4:0] ADDR_BAUD_CTL = 5'h08;
	localparam logic [4:0] ADDR_DIV_LOW = 5'h0C;
	localparam logic [4:0] ADDR_DIV_HIGH = 5'h10;
	localparam logic [4:0] ADDR_RX_DATA = 5'h14;
	localparam logic [4:0] ADDR_TX_DATA = 5'h18;
	localparam logic [4:0] ADDR_IRQ_CTL = 5'h1C;
	// transmit_status_control fields
	localparam int TX_MCS = 7;
	localparam int TX_N9 = 6;
	localparam int TX_EN = 5;
	localparam int TX_SYNC = 4;
	localparam int TX_HS = 2;
	localparam int TX_IDLE = 1;
	localparam int TX_D9 = 0;
	// receive_status_control fields
	localparam int RX_SPE = 7;
	localparam int RX_N9 = 6;
	localparam int RX_SRE = 5;
	localparam int RX_CRE = 4;
	localparam int RX_ADE = 3;
	localparam int RX_FE = 2;
	localparam int RX_OE = 1;
	localparam int RX_D9 = 0;
	// baud_control fields
	localparam int BC_WIDE = 3;
	// irq control fields (enables and flags)
	localparam int IC_RIE = 0;
	localparam int IC_TIE = 1;
	localparam int IC_PIE = 2;
	localparam int IC_GIE = 3;
	localparam int IC_SLEEP = 4;
	localparam int IC_RIF = 5;
	localparam int IC_TIF = 6;
	// Reset values
	localparam logic [7:0] RST_TX_CTL = 8'h02;
	localparam logic [7:0] RST_RX_CTL = 8'h00;
	localparam logic [7:0] RST_BAUD = 8'h00;
	localparam logic [7:0] RST_DIV = 8'h00;
	localparam logic [4:0] RST_IRQ = 5'h00;
endpackage : ssms_pkg

// ===== tb.sv
// Bench: Wishbone register tasks plus a remote peer on the pins.
// Assumes a pull-up on the shared data line.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [4:0] adr_i = 5'h00;
	logic [31:0] dat_i = 32'h00000000;
	logic [31:0] dat_o, rd;
	logic ack_o, ck_o, ck_oe_n_o, dt_o, dt_oe_n_o, p_ck, p_dt, p_oe_n;
	logic rx_irq_o, tx_irq_o, wake_o, vector_o;
	logic [8:0] rx;
	int failures = 0;
	int checks = 0;
	int ck_cnt = 0;
	wire ck_w = ck_oe_n_o ? p_ck : ck_o;
	wire dt_w = !dt_oe_n_o ? dt_o : (!p_oe_n ? p_dt : 1'b1);
	always #20 clk_i = ~clk_i;
	always @(posedge ck_o) if (!ck_oe_n_o) ck_cnt++;
	ssms_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ck_i(ck_w),
		.ck_o(ck_o), .ck_oe_n_o(ck_oe_n_o), .dt_i(dt_w), .dt_o(dt_o),
		.dt_oe_n_o(dt_oe_n_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o),
		.wake_o(wake_o), .vector_o(vector_o));
	ssms_peer peer (.ck_o(p_ck), .dt_o(p_dt), .dt_oe_n_o(p_oe_n),
		.dt_i(dt_w));
	task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 50) begin
			failures++;
			wrap_up();
		end
	endtask : wb
	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] v);
		checks++;
		if (v !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, v);
		end
	endtask : cmp
	task automatic rdc(input logic [4:0] a, input logic [7:0] e, string nm);
		wb(1'b0, a, 8'h00);
		cmp(nm, {24'h000000, e}, rd);
	endtask : rdc
	task automatic wrap_up;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(ssms_pkg::ADDR_TX_CTL, 8'h02, "txctl");
		rdc(ssms_pkg::ADDR_RX_CTL, 8'h00, "rxctl");
		rdc(5'h02, 8'h00, "unmapped");
		wb(1'b1, ssms_pkg::ADDR_DIV_HIGH, 8'hA5);
		rdc(ssms_pkg::ADDR_DIV_HIGH, 8'hA5, "divhi");
		$display("test regs done");
		wb(1'b1, ssms_pkg::ADDR_TX_CTL, 8'h10);
		wb(1'b1, ssms_pkg::ADDR_RX_CTL, 8'h90);
		wb(1'b1, ssms_pkg::ADDR_IRQ_CTL, 8'h15);
		peer.xfer(9'h03C, 8, 1'b1, rx);
		cmp("rx irq", 1, rx_irq_o);
		cmp("wake", 1, wake_o);
		peer.xfer(9'h0A5, 8, 1'b1, rx);
		peer.xfer(9'h05A, 8, 1'b1, rx);
		rdc(ssms_pkg::ADDR_RX_CTL, 8'h92, "overrun");
		rdc(ssms_pkg::ADDR_RX_DATA, 8'h3C, "rx one");
		rdc(ssms_pkg::ADDR_RX_DATA, 8'hA5, "rx two");
		cmp("rx irq off", 0, rx_irq_o);
		wb(1'b1, ssms_pkg::ADDR_RX_CTL, 8'h80);
		rdc(ssms_pkg::ADDR_RX_CTL, 8'h80, "oe clear");
		wb(1'b1, ssms_pkg::ADDR_RX_CTL, 8'hD0);
		peer.xfer(9'h1C3, 9, 1'b1, rx);
		rdc(ssms_pkg::ADDR_RX_CTL, 8'hD1, "ninth");
		rdc(ssms_pkg::ADDR_RX_DATA, 8'hC3, "low byte");
		$display("test slave rx done");
		wb(1'b1, ssms_pkg::ADDR_RX_CTL, 8'h80);
		wb(1'b1, ssms_pkg::ADDR_IRQ_CTL, 8'h16);
		wb(1'b1, ssms_pkg::ADDR_TX_CTL, 8'h30);
		wb(1'b1, ssms_pkg::ADDR_TX_DATA, 8'h96);
		wb(1'b1, ssms_pkg::ADDR_TX_DATA, 8'h69);
		cmp("tx held", 0, tx_irq_o);
		peer.xfer(9'h1FF, 8, 1'b0, rx);
		cmp("tx one", 32'h96, rx);
		cmp("tx irq", 1, tx_irq_o);
		cmp("tx wake", 1, wake_o);
		wb(1'b1, ssms_pkg::ADDR_IRQ_CTL, 8'h1E);
		cmp("vector", 1, vector_o);
		peer.xfer(9'h1FF, 8, 1'b0, rx);
		cmp("tx two", 32'h69, rx);
		cmp("dt release", 1, dt_oe_n_o);
		$display("test slave tx done");
		wb(1'b1, ssms_pkg::ADDR_RX_CTL, 8'h00);
		wb(1'b1, ssms_pkg::ADDR_DIV_LOW, 8'h03);
		wb(1'b1, ssms_pkg::ADDR_DIV_HIGH, 8'h00);
		wb(1'b1, ssms_pkg::ADDR_IRQ_CTL, 8'h01);
		wb(1'b1, ssms_pkg::ADDR_TX_CTL, 8'h90);
		wb(1'b1, ssms_pkg::ADDR_RX_CTL, 8'h80);
		cmp("ck drive", 0, ck_oe_n_o);
		ck_cnt = 0;
		wb(1'b1, ssms_pkg::ADDR_RX_CTL, 8'hA0);
		for (int n = 0; rx_irq_o !== 1'b1; n++) begin
			@(posedge clk_i);
			if (n > 2000) begin
				failures++;
				wrap_up();
			end
		end
		cmp("ck count", 8, ck_cnt);
		rdc(ssms_pkg::ADDR_RX_CTL, 8'h80, "sre clear");
		rdc(ssms_pkg::ADDR_RX_DATA, 8'hFF, "master rx");
		$display("test master rx done");
		wrap_up();
	end
endmodule : tb
